// *** hdl/gcg_pkg.sv ***
// Constants, register layout and types of the clock generator control block
package gcg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] GEN_CTRL_OFS = 12'h000;
	localparam logic [11:0] DIV_OFS      = 12'h004;
	localparam logic [11:0] PLL_CTRL_OFS = 12'h008;
	localparam logic [11:0] STATUS_OFS   = 12'h00c;

	// generator_control field positions
	localparam int GC_RUNSTDBY_BIT = 21;
	localparam int GC_DIVIDE_MODE_SELECT_BIT   = 20;
	localparam int GC_OE_BIT       = 19;
	localparam int GC_OFFLVL_BIT   = 18;
	localparam int GC_DUTYFIX_BIT  = 17;
	localparam int GC_GENON_BIT    = 16;
	localparam int GC_SRC_LSB      = 8;
	localparam int GC_SRC_W        = 5;

	// pll_control field positions
	localparam int PC_LOCKIGN_BIT = 12;
	localparam int PC_LOCK_TIMEOUT_SELECT_LSB   = 8;
	localparam int PC_LOCK_TIMEOUT_SELECT_W     = 3;
	localparam int PC_PLLEN_BIT   = 7;
	localparam int PC_REF_LSB     = 4;
	localparam int PC_REF_W       = 2;
	localparam int PC_FASTWK_BIT  = 3;
	localparam int PC_LOWPWR_BIT  = 2;
	localparam int PC_FILT_LSB    = 0;
	localparam int PC_FILT_W      = 2;

	// pll_status bit positions
	localparam int ST_LOCK_BIT    = 0;
	localparam int ST_TIMEOUT_BIT = 1;
	localparam int ST_PLLCLK_BIT  = 2;
	localparam int ST_STARTUP_BIT = 3;
	localparam int ST_GENRUN_BIT  = 4;

	////////////////////////////////////////////////////////////////////////
	// Sources and divider
	localparam int          NUM_SRC      = 32;
	localparam logic [4:0]  PIN_SRC_SEL  = 5'h01;
	localparam int          DIV_W        = 16;
	localparam logic [4:0]  PWR_EXP_MAX  = 5'h1f;
	localparam int          PER_W        = 33;
	localparam int          EDGE_W       = 34;

	// Lock timeout selections
	localparam logic [2:0]  LOCK_TIMEOUT_SELECT_OFF     = 3'h0;
	localparam logic [2:0]  LOCK_TIMEOUT_SELECT_MIN_SEL = 3'h4;
	localparam logic [3:0]  LOCK_TIMEOUT_SELECT_BASE_MS = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Timing at the 100 MHz bus clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam int STARTUP_NS    = 1000;
	localparam int STARTUP_CYC   =
		(STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_W     = 12;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic       run_standby;
		logic       divide_mode_select;
		logic       output_enable;
		logic       pin_off_level;
		logic       duty_cycle_fix;
		logic       generator_on;
		logic [4:0] source_select;
	} gcg_gen_ctrl_s;

	typedef struct packed {
		logic       pll_enable;
		logic       lock_ignore;
		logic [2:0] lock_timeout_select;
		logic [1:0] pll_reference_select;
		logic       fast_wake;
		logic       pll_low_power;
		logic [1:0] filter_select;
	} gcg_pll_ctrl_s;

	typedef enum logic [1:0] {
		PLL_OFF,
		PLL_STARTUP,
		PLL_RUN
	} gcg_pll_state_e;

	localparam gcg_gen_ctrl_s GEN_CTRL_RST = '0;
	localparam gcg_pll_ctrl_s PLL_CTRL_RST = '0;
	localparam logic [15:0]   DIV_RST      = 16'h0000;

endpackage

// *** hdl/gcg_ctrl.sv ***
// Generic clock generator and PLL digital control with APB registers
// Function
// - Without run-in-standby the generator stops in standby and its pin shows the off level; with it, it keeps running and driving.
// - In linear mode the output is the source divided by the division factor.
// - In power mode the output is the source divided by two to the power of factor plus one.
// - Output enable routes the clock to the pin unless that pin is the chosen source.
// - The off level sets the pin, when it is not the chosen source, whenever the generator is off or output enable is clear.
// - Duty-cycle fix gives a 50/50 output for odd factors; without it odd linear factors from three up are uneven.
// - The generator-on bit switches the generator on and off.
// - A five-bit source select picks the generator's source.
// - Normally the PLL output is gated while lock is low; lock-ignore lets it run regardless.
// - Lock timeout select 0 disables it, 1 to 3 are reserved, 4 to 7 flag after 8 to 11 ms unlocked.
// - Reference select picks slow crystal, main crystal, generic clock, or reserved.
// - Without fast wake the PLL output waits for startup and lock; with it only for startup.
// - The low-power bit deselects the time-to-digital converter.
// - The filter field picks the default or the low-bandwidth loop filter.
`timescale 1ns/100ps
module gcg_ctrl #(
	parameter int CYC_PER_MS = gcg_pkg::CYC_PER_MS
) (
	input  wire logic                      pclk,            // Bus clock
	input  wire logic                      presetn,         // Async reset
	input  wire logic                      psel,            // APB select
	input  wire logic                      penable,         // APB enable
	input  wire logic                      pwrite,          // APB write
	input  wire logic [gcg_pkg::ADDR_W-1:0] paddr,          // APB address
	input  wire logic [31:0]               pwdata,          // APB write data
	output logic      [31:0]               prdata,          // APB read data
	output logic                           pready,          // APB ready
	output logic                           pslverr,         // APB error
	input  wire logic [gcg_pkg::NUM_SRC-1:0] src_clks,      // Clock sources
	input  wire logic                      standby,         // Standby mode
	input  wire logic                      gen_pin_in,      // Pin input level
	output logic                           gen_pin_out,     // Pin output level
	output logic                           gen_pin_oe_n,    // Pin drive, low
	output logic                           gen_clk_out,     // Generated clock
	input  wire logic                      pll_lock,        // PLL lock level
	output logic                           pll_clk_gate,    // PLL output on
	output logic      [1:0]                pll_ref_sel,     // PLL reference
	output logic                           pll_tdc_sel,     // TDC selected
	output logic      [1:0]                pll_filter_sel,  // Loop filter
	output logic                           pll_timeout      // Lock timed out
);

	////////////////////////////////////////////////////////////////////////
	// Register bus
	gcg_pkg::gcg_gen_ctrl_s       gen_ctrl, next_gen_ctrl;
	gcg_pkg::gcg_pll_ctrl_s       pll_ctrl, next_pll_ctrl;
	logic [gcg_pkg::DIV_W-1:0]    div_fac,  next_div_fac;
	logic [31:0]                  next_prdata;
	logic                         next_pslverr;
	logic                         timeout_clr;
	logic [31:0]                  status_word;
	logic                         pll_locked_st;
	logic                         startup_done;
	logic                         gen_run;
	logic                         wr_acc;

	assign wr_acc = psel & penable & pwrite;

	always_comb begin
		next_gen_ctrl = gen_ctrl;
		next_pll_ctrl = pll_ctrl;
		next_div_fac  = div_fac;
		timeout_clr   = 1'b0;
		next_prdata   = 32'h0000_0000;
		next_pslverr  = 1'b0;
		status_word   = 32'h0000_0000;
		status_word[gcg_pkg::ST_LOCK_BIT]    = pll_lock;
		status_word[gcg_pkg::ST_TIMEOUT_BIT] = pll_timeout;
		status_word[gcg_pkg::ST_PLLCLK_BIT]  = pll_clk_gate;
		status_word[gcg_pkg::ST_STARTUP_BIT] = startup_done;
		status_word[gcg_pkg::ST_GENRUN_BIT]  = gen_run;
		// Answer prepared in setup so it comes from a flop in access
		if (psel & ~penable) begin
			case (paddr)
				gcg_pkg::GEN_CTRL_OFS: begin
					next_prdata[gcg_pkg::GC_RUNSTDBY_BIT] = gen_ctrl.run_standby;
					next_prdata[gcg_pkg::GC_DIVIDE_MODE_SELECT_BIT] =
						gen_ctrl.divide_mode_select;
					next_prdata[gcg_pkg::GC_OE_BIT] = gen_ctrl.output_enable;
					next_prdata[gcg_pkg::GC_OFFLVL_BIT] = gen_ctrl.pin_off_level;
					next_prdata[gcg_pkg::GC_DUTYFIX_BIT] =
						gen_ctrl.duty_cycle_fix;
					next_prdata[gcg_pkg::GC_GENON_BIT] = gen_ctrl.generator_on;
					next_prdata[gcg_pkg::GC_SRC_LSB +: gcg_pkg::GC_SRC_W] =
						gen_ctrl.source_select;
				end
				gcg_pkg::DIV_OFS:
					next_prdata[gcg_pkg::DIV_W-1:0] = div_fac;
				gcg_pkg::PLL_CTRL_OFS: begin
					next_prdata[gcg_pkg::PC_LOCKIGN_BIT] = pll_ctrl.lock_ignore;
					next_prdata[gcg_pkg::PC_LOCK_TIMEOUT_SELECT_LSB +: gcg_pkg::PC_LOCK_TIMEOUT_SELECT_W] =
						pll_ctrl.lock_timeout_select;
					next_prdata[gcg_pkg::PC_PLLEN_BIT] = pll_ctrl.pll_enable;
					next_prdata[gcg_pkg::PC_REF_LSB +: gcg_pkg::PC_REF_W] =
						pll_ctrl.pll_reference_select;
					next_prdata[gcg_pkg::PC_FASTWK_BIT] = pll_ctrl.fast_wake;
					next_prdata[gcg_pkg::PC_LOWPWR_BIT] = pll_ctrl.pll_low_power;
					next_prdata[gcg_pkg::PC_FILT_LSB +: gcg_pkg::PC_FILT_W] =
						pll_ctrl.filter_select;
				end
				gcg_pkg::STATUS_OFS:
					next_prdata = status_word;
				default:
					next_pslverr = 1'b1;
			endcase
		end
		if (wr_acc) begin
			case (paddr)
				gcg_pkg::GEN_CTRL_OFS: begin
					next_gen_ctrl.run_standby = pwdata[gcg_pkg::GC_RUNSTDBY_BIT];
					next_gen_ctrl.divide_mode_select =
						pwdata[gcg_pkg::GC_DIVIDE_MODE_SELECT_BIT];
					next_gen_ctrl.output_enable = pwdata[gcg_pkg::GC_OE_BIT];
					next_gen_ctrl.pin_off_level = pwdata[gcg_pkg::GC_OFFLVL_BIT];
					next_gen_ctrl.duty_cycle_fix =
						pwdata[gcg_pkg::GC_DUTYFIX_BIT];
					next_gen_ctrl.generator_on = pwdata[gcg_pkg::GC_GENON_BIT];
					next_gen_ctrl.source_select =
						pwdata[gcg_pkg::GC_SRC_LSB +: gcg_pkg::GC_SRC_W];
				end
				gcg_pkg::DIV_OFS:
					next_div_fac = pwdata[gcg_pkg::DIV_W-1:0];
				gcg_pkg::PLL_CTRL_OFS: begin
					next_pll_ctrl.lock_ignore = pwdata[gcg_pkg::PC_LOCKIGN_BIT];
					next_pll_ctrl.lock_timeout_select =
						pwdata[gcg_pkg::PC_LOCK_TIMEOUT_SELECT_LSB +: gcg_pkg::PC_LOCK_TIMEOUT_SELECT_W];
					next_pll_ctrl.pll_enable = pwdata[gcg_pkg::PC_PLLEN_BIT];
					next_pll_ctrl.pll_reference_select =
						pwdata[gcg_pkg::PC_REF_LSB +: gcg_pkg::PC_REF_W];
					next_pll_ctrl.fast_wake = pwdata[gcg_pkg::PC_FASTWK_BIT];
					next_pll_ctrl.pll_low_power = pwdata[gcg_pkg::PC_LOWPWR_BIT];
					next_pll_ctrl.filter_select =
						pwdata[gcg_pkg::PC_FILT_LSB +: gcg_pkg::PC_FILT_W];
				end
				gcg_pkg::STATUS_OFS:
					timeout_clr = pwdata[gcg_pkg::ST_TIMEOUT_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_ctrl <= gcg_pkg::GEN_CTRL_RST;
			pll_ctrl <= gcg_pkg::PLL_CTRL_RST;
			div_fac  <= gcg_pkg::DIV_RST;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
			pready   <= 1'b0;
		end else begin
			gen_ctrl <= next_gen_ctrl;
			pll_ctrl <= next_pll_ctrl;
			div_fac  <= next_div_fac;
			prdata   <= next_prdata;
			pslverr  <= next_pslverr;
			pready   <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PLL control
	gcg_pkg::gcg_pll_state_e  pll_st, next_pll_st;
	logic [gcg_pkg::STARTUP_W-1:0] su_cnt, next_su_cnt;
	logic [31:0]              ms_cnt, next_ms_cnt;
	logic [3:0]               lk_ms, next_lk_ms;
	logic [3:0]               limit_ms;
	logic                     next_timeout, next_clk_gate;

	assign pll_locked_st = pll_lock;
	assign startup_done  = (pll_st == gcg_pkg::PLL_RUN);

	always_comb begin
		next_pll_st  = pll_st;
		next_su_cnt  = su_cnt;
		next_ms_cnt  = ms_cnt;
		next_lk_ms   = lk_ms;
		next_timeout = pll_timeout & ~timeout_clr;
		limit_ms     = gcg_pkg::LOCK_TIMEOUT_SELECT_BASE_MS
			+ {1'b0, pll_ctrl.lock_timeout_select - gcg_pkg::LOCK_TIMEOUT_SELECT_MIN_SEL};
		case (pll_st)
			gcg_pkg::PLL_OFF: begin
				next_su_cnt = '0;
				if (pll_ctrl.pll_enable)
					next_pll_st = gcg_pkg::PLL_STARTUP;
			end
			gcg_pkg::PLL_STARTUP: begin
				next_su_cnt = su_cnt + 1'b1;
				if (su_cnt == gcg_pkg::STARTUP_W'(gcg_pkg::STARTUP_CYC - 1))
					next_pll_st = gcg_pkg::PLL_RUN;
			end
			gcg_pkg::PLL_RUN: ;
			default: next_pll_st = gcg_pkg::PLL_OFF;
		endcase
		if (!pll_ctrl.pll_enable)
			next_pll_st = gcg_pkg::PLL_OFF;
		if (!pll_ctrl.pll_enable || pll_locked_st
				|| pll_ctrl.lock_timeout_select < gcg_pkg::LOCK_TIMEOUT_SELECT_MIN_SEL) begin
			next_ms_cnt = '0;
			next_lk_ms  = '0;
		end else if (ms_cnt == 32'(CYC_PER_MS - 1)) begin
			next_ms_cnt = '0;
			if (lk_ms != limit_ms)
				next_lk_ms = lk_ms + 1'b1;
		end else begin
			next_ms_cnt = ms_cnt + 1'b1;
		end
		// Set wins over a same-cycle clear
		if (next_lk_ms == limit_ms && lk_ms != limit_ms)
			next_timeout = 1'b1;
		if (!pll_ctrl.pll_enable)
			next_clk_gate = 1'b0;
		else if (pll_ctrl.lock_ignore)
			next_clk_gate = 1'b1;
		else if (pll_ctrl.fast_wake)
			next_clk_gate = startup_done;
		else
			next_clk_gate = startup_done & pll_locked_st;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_st         <= gcg_pkg::PLL_OFF;
			su_cnt         <= '0;
			ms_cnt         <= '0;
			lk_ms          <= '0;
			pll_timeout    <= 1'b0;
			pll_clk_gate   <= 1'b0;
			pll_ref_sel    <= '0;
			pll_tdc_sel    <= 1'b1;
			pll_filter_sel <= '0;
		end else begin
			pll_st         <= next_pll_st;
			su_cnt         <= next_su_cnt;
			ms_cnt         <= next_ms_cnt;
			lk_ms          <= next_lk_ms;
			pll_timeout    <= next_timeout;
			pll_clk_gate   <= next_clk_gate;
			pll_ref_sel    <= pll_ctrl.pll_reference_select;
			pll_tdc_sel    <= ~pll_ctrl.pll_low_power;
			pll_filter_sel <= pll_ctrl.filter_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Generic clock generator
	logic [gcg_pkg::NUM_SRC-1:0]  srcs;
	logic                         src_now, src_q, src_edge, src_is_pin;
	logic [gcg_pkg::PER_W-1:0]    new_per, cur_per, next_cur_per;
	logic [gcg_pkg::EDGE_W-1:0]   new_hi, cur_hi, next_cur_hi;
	logic [gcg_pkg::EDGE_W-1:0]   e_cnt, next_e_cnt, last_e;
	logic                         active, next_active;
	logic                         next_gen, next_pin;
	logic [4:0]                   pexp;

	always_comb begin
		srcs = src_clks;
		srcs[gcg_pkg::PIN_SRC_SEL] = gen_pin_in;
	end

	assign src_now    = srcs[gen_ctrl.source_select];
	assign src_edge   = src_now ^ src_q;
	assign src_is_pin = (gen_ctrl.source_select == gcg_pkg::PIN_SRC_SEL);
	// run only when on, and in standby only if allowed
	assign gen_run    = gen_ctrl.generator_on
		& (~standby | gen_ctrl.run_standby);
	assign last_e     = {cur_per, 1'b0} - 1'b1;

	always_comb begin
		pexp = (div_fac > gcg_pkg::DIV_W'(gcg_pkg::PWR_EXP_MAX))
			? gcg_pkg::PWR_EXP_MAX : div_fac[4:0];
		if (gen_ctrl.divide_mode_select)
			new_per = gcg_pkg::PER_W'(1) << (6'(pexp) + 6'h01);
		// linear, zero and one pass through
		else if (div_fac <= gcg_pkg::DIV_W'(1))
			new_per = gcg_pkg::PER_W'(1);
		else
			new_per = gcg_pkg::PER_W'(div_fac);
		// high edges, full half for the fix, rising-edge floor without
		if (gen_ctrl.duty_cycle_fix)
			new_hi = {1'b0, new_per};
		else
			new_hi = {1'b0, new_per[gcg_pkg::PER_W-1:1], 1'b0};
	end

	always_comb begin
		next_active  = active;
		next_e_cnt   = e_cnt;
		next_cur_per = cur_per;
		next_cur_hi  = cur_hi;
		if (!gen_run) begin
			next_active = 1'b0;
			next_e_cnt  = '0;
		end else if (src_edge) begin
			if (!active) begin
				// Start aligned to a rising source edge
				if (src_now) begin
					next_active  = 1'b1;
					next_e_cnt   = '0;
					next_cur_per = new_per;
					next_cur_hi  = new_hi;
				end
			// reload only at period end, no runt pulses
			end else if (e_cnt == last_e) begin
				next_e_cnt   = '0;
				next_cur_per = new_per;
				next_cur_hi  = new_hi;
			end else begin
				next_e_cnt = e_cnt + 1'b1;
			end
		end
		if (!next_active)
			next_gen = 1'b0;
		else if (next_cur_per == gcg_pkg::PER_W'(1))
			next_gen = src_now;
		else
			next_gen = (next_e_cnt < next_cur_hi);
		// pin drives clock or the off level
		if (gen_run && gen_ctrl.output_enable && !src_is_pin)
			next_pin = next_gen;
		else
			next_pin = gen_ctrl.pin_off_level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q        <= 1'b0;
			active       <= 1'b0;
			e_cnt        <= '0;
			cur_per      <= gcg_pkg::PER_W'(1);
			cur_hi       <= '0;
			gen_clk_out  <= 1'b0;
			gen_pin_out  <= 1'b0;
			gen_pin_oe_n <= 1'b1;
		end else begin
			src_q        <= src_now;
			active       <= next_active;
			e_cnt        <= next_e_cnt;
			cur_per      <= next_cur_per;
			cur_hi       <= next_cur_hi;
			gen_clk_out  <= next_gen;
			gen_pin_out  <= next_pin;
			// pin left undriven when it is the source
			gen_pin_oe_n <= src_is_pin;
		end
	end

endmodule // gcg_ctrl

// *** dv/gcg_ctrl_props.sv ***
// Port checker for the clock generator control block
`timescale 1ns/100ps
module gcg_ctrl_props (
	input wire logic        pclk,           // Bus clock
	input wire logic        presetn,        // Async reset
	input wire logic        psel,           // APB select
	input wire logic        penable,        // APB enable
	input wire logic        pwrite,         // APB write
	input wire logic [11:0] paddr,          // APB address
	input wire logic [31:0] pwdata,         // APB write data
	input wire logic        standby,        // Standby mode
	input wire logic        pll_lock,       // PLL lock
	input wire logic        gen_clk_out,    // Generated clock
	input wire logic        gen_pin_out,    // Pin level
	input wire logic        gen_pin_oe_n,   // Pin drive, low
	input wire logic        pll_clk_gate,   // PLL output on
	input wire logic [1:0]  pll_ref_sel,    // PLL reference
	input wire logic        pll_tdc_sel,    // TDC selected
	input wire logic [1:0]  pll_filter_sel, // Loop filter
	input wire logic        pll_timeout     // Lock timed out
);
	logic [31:0] gc;
	logic [31:0] pc;
	logic        stby_q;
	int          gage;
	int          page;
	wire         wr = psel && penable && pwrite;
	// Generator stops at once but its outputs are registered, so wait after each change
	wire         gq = gage > 24;
	wire         pq = page > 4;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gc <= '0;
			pc <= '0;
			stby_q <= 1'b0;
			gage <= 0;
			page <= 0;
		end else begin
			stby_q <= standby;
			if (wr && paddr == gcg_pkg::GEN_CTRL_OFS) gc <= pwdata;
			if (wr && paddr == gcg_pkg::PLL_CTRL_OFS) pc <= pwdata;
			if ((wr && paddr == gcg_pkg::GEN_CTRL_OFS) || standby != stby_q)
				gage <= 0;
			else if (gage < 31) gage <= gage + 1;
			if (wr && paddr == gcg_pkg::PLL_CTRL_OFS) page <= 0;
			else if (page < 31) page <= page + 1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_unlocked;
		!pll_lock [*3];
	endsequence
	a_pin_release: assert property (
		gq && gc[12:8] == gcg_pkg::PIN_SRC_SEL |-> gen_pin_oe_n)
		else $error("pin driven while it is the source");
	a_pin_off: assert property (
		gq && !gc[19] && gc[12:8] != 5'h01 |-> gen_pin_out == gc[18])
		else $error("pin not at off level");
	a_gen_off: assert property (
		gq && !gc[16] |-> !gen_clk_out [*4])
		else $error("clock runs while generator off");
	a_stby_stop: assert property (
		gq && standby && !gc[21] |-> !gen_clk_out)
		else $error("clock runs in standby");
	a_lock_gate: assert property (
		s_unlocked ##0 (pq && !pc[12] && !pc[3]) |=> !pll_clk_gate)
		else $error("PLL output passed without lock");
	a_bypass_gate: assert property (
		pq && pc[12] && pc[7] |-> pll_clk_gate)
		else $error("PLL output gated in bypass");
	a_ref_copy: assert property (
		pq |-> pll_ref_sel == pc[5:4])
		else $error("reference select wrong");
	a_tdc_sel: assert property (
		pq |-> pll_tdc_sel == !pc[2])
		else $error("converter select wrong");
	a_filt_copy: assert property (
		pq |-> pll_filter_sel == pc[1:0])
		else $error("filter select wrong");
	a_no_timeout: assert property (
		pq && !pc[10] && !pll_timeout |=> !pll_timeout)
		else $error("timeout with timeout off");
endmodule // gcg_ctrl_props

bind gcg_ctrl gcg_ctrl_props u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .standby, .pll_lock, .gen_clk_out,
	.gen_pin_out, .gen_pin_oe_n, .pll_clk_gate, .pll_ref_sel,
	.pll_tdc_sel, .pll_filter_sel, .pll_timeout);

// *** dv/gcg_periph_model.sv ***
// Source oscillators and a consumer that times the generated clock
`timescale 1ns/100ps
module gcg_periph_model (
	input  wire logic        pclk,        // Bus clock
	input  wire logic        presetn,     // Async reset
	input  wire logic        gen_clk_out, // Generated clock
	output logic      [31:0] src_clks,    // Source levels
	output logic             pin_ext,     // Outside level on pin
	output int               per_cyc,     // Last period, cycles
	output int               hi_cyc,      // Last high time, cycles
	output int               rises        // Rising edges seen
);
	int   cnt;
	int   since;
	logic last;
	// Source k has a half period of k+1 cycles
	for (genvar k = 0; k < 32; k++) begin : g_src
		assign src_clks[k] = (cnt / (k + 1)) % 2 == 1;
	end
	// Keeps moving so a stale pin level cannot pass
	assign pin_ext = cnt[1];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			since <= 0;
			last <= 1'b0;
			per_cyc <= 0;
			hi_cyc <= 0;
			rises <= 0;
		end else begin
			cnt <= cnt + 1;
			last <= gen_clk_out;
			since <= since + 1;
			if (gen_clk_out && !last) begin
				per_cyc <= since;
				since <= 1;
				rises <= rises + 1;
			end
			if (!gen_clk_out && last) hi_cyc <= since;
		end
	end
endmodule // gcg_periph_model

// *** dv/gcg_ctrl_test.sv ***
// Self-checking bench for the clock generator control block
`timescale 1ns/100ps
module gcg_ctrl_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, src_clks;
	logic        standby, pll_lock, pin_ext, gen_pin_out, gen_pin_oe_n;
	logic        gen_clk_out, pll_clk_gate, pll_tdc_sel, pll_timeout;
	logic [1:0]  pll_ref_sel, pll_filter_sel;
	int          per_cyc, hi_cyc, rises, mismatches, tests_run;
	wire         pin = gen_pin_oe_n ? pin_ext : gen_pin_out;

	gcg_ctrl #(.CYC_PER_MS(10)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_clks,
		.standby, .gen_pin_in(pin), .gen_pin_out, .gen_pin_oe_n,
		.gen_clk_out, .pll_lock, .pll_clk_gate, .pll_ref_sel,
		.pll_tdc_sel, .pll_filter_sel, .pll_timeout);
	gcg_periph_model u_model (.pclk, .presetn, .gen_clk_out, .src_clks,
		.pin_ext, .per_cyc, .hi_cyc, .rises);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic hang(input string nm);
		mismatches++;
		$display("MISMATCH %s exp done got timeout", nm);
		report_and_stop();
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang("pready");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0, q, e);
			chk("reset value", 32'h0, q);
		end
		wr(gcg_pkg::GEN_CTRL_OFS, 32'hffffffff);
		apb(1'b0, gcg_pkg::GEN_CTRL_OFS, 32'h0, q, e);
		chk("generator_control", 32'h003f1f00, q);
		apb(1'b0, 12'h010, 32'h0, q, e);
		chk("unmapped error", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, q);
		wr(gcg_pkg::GEN_CTRL_OFS, 32'h0);
	endtask
	task automatic run_div(input logic [31:0] g, input logic [15:0] dv,
		input int per, hi);
		int r0;
		int n;
		wr(gcg_pkg::DIV_OFS, {16'h0, dv});
		wr(gcg_pkg::GEN_CTRL_OFS, g);
		r0 = rises;
		n = 0;
		while (rises < r0 + 3 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) hang("generated clock");
		chk("period", 32'(per), 32'(per_cyc));
		chk("high time", 32'(hi), 32'(hi_cyc));
	endtask
	task automatic t_div;
		run_div(32'h00030200, 16'h0000, 6, 3);
		run_div(32'h00030200, 16'h0001, 6, 3);
		run_div(32'h00030300, 16'h0003, 24, 12);
		run_div(32'h00010300, 16'h0003, 24, 8);
		run_div(32'h00011f00, 16'h0002, 128, 64);
		run_div(32'h00110200, 16'h0001, 24, 12);
		run_div(32'h00110400, 16'h0000, 20, 10);
	endtask
	task automatic t_pin;
		int t;
		int h;
		wr(gcg_pkg::DIV_OFS, 32'h1);
		wr(gcg_pkg::GEN_CTRL_OFS, 32'h00090200);
		idle(30);
		chk("pin drive", 32'h0, 32'(gen_pin_oe_n));
		t = 0;
		h = 0;
		for (int i = 0; i < 12; i++) begin
			@(posedge pclk);
			if (gen_pin_out !== gen_clk_out) t++;
			if (gen_clk_out === 1'b1) h++;
		end
		chk("pin follows clock", 32'h0, 32'(t));
		chk("pin high cycles", 32'h6, 32'(h));
		wr(gcg_pkg::GEN_CTRL_OFS, 32'h00090100);
		idle(30);
		chk("pin released", 32'h1, 32'(gen_pin_oe_n));
		for (int i = 0; i < 4; i++) begin
			wr(gcg_pkg::GEN_CTRL_OFS, (i[1] ? 32'h00080200 : 32'h00010200)
				| (32'(i[0]) << 18));
			idle(30);
			chk("off level", 32'(i[0]), 32'(gen_pin_out));
			if (i[1]) chk("generator off", 32'h0, 32'(gen_clk_out));
		end
	endtask
	task automatic t_stby;
		int h;
		wr(gcg_pkg::GEN_CTRL_OFS, 32'h000d0200);
		standby <= 1'b1;
		idle(30);
		h = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (gen_clk_out !== 1'b0) h++;
		end
		chk("standby stopped", 32'h0, 32'(h));
		chk("standby pin", 32'h1, 32'(gen_pin_out));
		run_div(32'h00230200, 16'h0001, 6, 3);
		standby <= 1'b0;
	endtask
	task automatic t_pll;
		int n;
		int x;
		for (int i = 0; i < 4; i++) begin
			wr(gcg_pkg::PLL_CTRL_OFS, 32'h80 | (32'(i) << 4)
				| (32'(i % 2) << 2) | 32'(i));
			idle(3);
			chk("reference", 32'(i), 32'(pll_ref_sel));
			chk("filter", 32'(i), 32'(pll_filter_sel));
			chk("tdc select", 32'(i % 2 == 0), 32'(pll_tdc_sel));
		end
		wr(gcg_pkg::PLL_CTRL_OFS, 32'h0);
		pll_lock <= 1'b1;
		wr(gcg_pkg::PLL_CTRL_OFS, 32'h80);
		idle(50);
		chk("gate in startup", 32'h0, 32'(pll_clk_gate));
		idle(60);
		chk("gate locked", 32'h1, 32'(pll_clk_gate));
		pll_lock <= 1'b0;
		idle(6);
		chk("gate unlocked", 32'h0, 32'(pll_clk_gate));
		wr(gcg_pkg::PLL_CTRL_OFS, 32'h1080);
		idle(6);
		chk("gate bypass", 32'h1, 32'(pll_clk_gate));
		wr(gcg_pkg::PLL_CTRL_OFS, 32'h0);
		wr(gcg_pkg::PLL_CTRL_OFS, 32'h88);
		idle(50);
		chk("fast wake startup", 32'h0, 32'(pll_clk_gate));
		idle(60);
		chk("gate fast wake", 32'h1, 32'(pll_clk_gate));
		for (int s = 0; s < 8; s++) begin
			wr(gcg_pkg::PLL_CTRL_OFS, 32'h0);
			wr(gcg_pkg::STATUS_OFS, 32'h2);
			idle(2);
			chk("timeout cleared", 32'h0, 32'(pll_timeout));
			wr(gcg_pkg::PLL_CTRL_OFS, 32'h80 | (32'(s) << 8));
			n = 0;
			while (pll_timeout !== 1'b1 && n < 150) begin
				@(posedge pclk);
				n++;
			end
			x = (s >= 4) ? (s + 4) * 10 : 150;
			chk("timeout near", 32'h1, 32'(n >= x - 3 && n <= x + 3));
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		standby = 1'b0;
		pll_lock = 1'b0;
		mismatches = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_div();
		t_pin();
		t_stby();
		t_pll();
		report_and_stop();
	end
endmodule // gcg_ctrl_test
